/* verilog/cmbf_fill.sv */
// Decided for this implementation: the APB interface to the registers and the register addresses.
module cmbf_fill
	import cmbf_pkg::*;
#(
	parameter int DEPTH     = 1024,
	parameter int FRAME_CYC = CMBF_FRAME_CYC
) (
	input  wire logic        pclk,      // System clock, 125 MHz.
	input  wire logic        presetn,   // Asynchronous reset, active low.
	input  wire logic        psel,      // APB select.
	input  wire logic        penable,   // APB enable.
	input  wire logic        pwrite,    // APB direction.
	input  wire logic [11:0] paddr,     // APB byte address.
	input  wire logic [31:0] pwdata,    // APB write data.
	output logic [31:0]      prdata,    // APB read data.
	output logic             pready,    // APB ready.
	output logic             pslverr,   // APB error.
	output cmbf_wr_t         mem_wr,    // Connection memory write port.
	output logic             busy       // Fill running.
);
	// Fill sequencer states, one-hot.
	typedef enum logic [1:0] {
		CMBF_IDLE = 2'b01,
		CMBF_FILL = 2'b10
	} cmbf_state_t;

	// Highest word address of the connection memories.
	localparam logic [9:0] LAST_ADDR  = 10'(DEPTH - 1);
	// Frame count whose closing pulse completes the fill.
	localparam logic [1:0] LAST_FRAME = 2'(CMBF_FILL_FRAMES - 1);

	// Sequencer state.
	cmbf_state_t state_q;
	cmbf_state_t state_d;
	logic [9:0]  addr_q;
	logic [9:0]  addr_d;
	logic [1:0]  frames_q;
	logic [1:0]  frames_d;
	cmbf_wr_t    wr_q;
	cmbf_wr_t    wr_d;

	// Software visible registers.
	logic [15:0] ctrl_q;
	logic [15:0] ctrl_d;
	logic        master_q;
	logic        master_d;

	// Read data, captured in the setup cycle so that it comes from a flip-flop.
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// Bus decode and sequencer events.
	logic        frame_tick;
	logic        wr_acc;
	logic        setup_rd;
	logic        sel_ctrl;
	logic        sel_main;
	logic        sel_stat;
	logic        addr_ok;
	logic        fill_abort;
	logic        fill_done;

	// Provides the frame pulse that paces the fill.
	cmbf_frame_div #(.FRAME_CYC(FRAME_CYC)) u_div (
		.pclk       (pclk),
		.presetn    (presetn),
		.frame_tick (frame_tick)
	);

	// Decodes the byte address into one register select.
	always_comb begin
		sel_ctrl = 1'b0;
		sel_main = 1'b0;
		sel_stat = 1'b0;
		if (paddr == CMBF_OFS_CONTROL) begin
			sel_ctrl = 1'b1;
		end else if (paddr == CMBF_OFS_MAIN) begin
			sel_main = 1'b1;
		end else if (paddr == CMBF_OFS_STATUS) begin
			sel_stat = 1'b1;
		end
	end

	// Bus handshake: no wait states, unmapped addresses answer with an error.
	assign addr_ok  = sel_ctrl || sel_main || sel_stat;
	assign wr_acc   = psel && penable && pwrite;
	assign setup_rd = psel && !penable && !pwrite;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !addr_ok;

	// A control write with the enable low stops a running fill at once.
	assign fill_abort = wr_acc && sel_ctrl && !pwdata[CMBF_EN_POS];
	// The fill ends on the closing pulse of its last frame unless aborted.
	assign fill_done  = (state_q == CMBF_FILL) && !fill_abort && frame_tick
		&& (frames_q == LAST_FRAME);

	// Next values of the software registers.
	always_comb begin
		ctrl_d   = ctrl_q;
		master_d = master_q;
		if (wr_acc && sel_ctrl) begin
			ctrl_d = pwdata[15:0] & CMBF_CONTROL_MASK;
		end else if (wr_acc && sel_main) begin
			master_d = pwdata[CMBF_MASTER_POS];
		end
		// Completion clears the enable, even against a write in the same cycle.
		if (fill_done) begin
			ctrl_d[CMBF_EN_POS] = 1'b0;
		end
	end

	// Registers the software registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q   <= CMBF_CONTROL_RST;
			master_q <= 1'b0;
		end else begin
			ctrl_q   <= ctrl_d;
			master_q <= master_d;
		end
	end

	// Next state of the fill sequencer and the memory write it issues.
	always_comb begin
		state_d  = state_q;
		addr_d   = addr_q;
		frames_d = frames_q;
		wr_d     = '0;
		case (state_q)
			CMBF_IDLE: begin
				if (master_q && ctrl_q[CMBF_EN_POS]) begin
					state_d  = CMBF_FILL;
					addr_d   = 10'h000;
					frames_d = 2'h0;
				end
			end
			CMBF_FILL: begin
				if (fill_abort) begin
					state_d = CMBF_IDLE;
				end else if (fill_done) begin
					state_d  = CMBF_IDLE;
					frames_d = frames_q + 2'h1;
				end else begin
					// The address parks on the last word once every word is written.
					if (addr_q != LAST_ADDR) begin
						addr_d = addr_q + 10'h001;
					end
					wr_d.we      = 1'b1;
					wr_d.addr    = addr_q;
					wr_d.bp_word = {ctrl_q[CMBF_BP_POS +: 3], 13'h0000};
					wr_d.lo_word = {ctrl_q[CMBF_LP_POS +: 3], 13'h0000};
					wr_d.hi_word = 16'h0000;
					if (frame_tick) begin
						frames_d = frames_q + 2'h1;
					end
				end
			end
			default: begin
				state_d = CMBF_IDLE;
			end
		endcase
	end

	// Registers the fill sequencer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q  <= CMBF_IDLE;
			addr_q   <= 10'h000;
			frames_q <= 2'h0;
			wr_q     <= '0;
		end else begin
			state_q  <= state_d;
			addr_q   <= addr_d;
			frames_q <= frames_d;
			wr_q     <= wr_d;
		end
	end

	// The write port comes straight from flip-flops; the busy level is decoded from the state flip-flops.
	assign mem_wr = wr_q;
	assign busy   = (state_q == CMBF_FILL);

	// Selects read data in the setup cycle; it stands through the access cycle.
	always_comb begin
		rdata_d = 32'h00000000;
		if (setup_rd && sel_ctrl) begin
			rdata_d = {16'h0000, ctrl_q};
		end else if (setup_rd && sel_main) begin
			rdata_d = {31'h00000000, master_q};
		end else if (setup_rd && sel_stat) begin
			rdata_d = {30'h00000000, frames_q != 2'h0, busy};
		end
	end

	// Registers the read data; it reads zero outside a read access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign prdata = rdata_q;
endmodule : cmbf_fill

/* verilog/cmbf_pkg.sv */
// Function
// - Fill starts only when master allow and fill enable are both high.
// - Backplane words get the backplane pattern in bits 15 to 13.
// - Backplane words have bits 12 to 0 cleared.
// - Local low words get the local pattern in bits 15 to 13.
// - Local low bits 12 to 0 and all local high bits are cleared.
// - Control register holds backplane pattern 8-6, local pattern 5-3, enable bit 2.
package cmbf_pkg;
	localparam logic [11:0] CMBF_OFS_CONTROL  = 12'h000;
	localparam logic [11:0] CMBF_OFS_MAIN     = 12'h004;
	localparam logic [11:0] CMBF_OFS_STATUS   = 12'h008;
	localparam int          CMBF_BP_POS       = 6;
	localparam int          CMBF_LP_POS       = 3;
	localparam int          CMBF_EN_POS       = 2;
	localparam int          CMBF_MASTER_POS   = 0;
	localparam logic [15:0] CMBF_CONTROL_RST  = 16'h0000;
	localparam logic [15:0] CMBF_CONTROL_MASK = 16'h01FC;
	localparam int          CMBF_PAT_LSB      = 13;
	localparam int          CMBF_FILL_FRAMES  = 2;
	localparam int          CMBF_FRAME_NS     = 125000;
	localparam int          CMBF_CLK_NS       = 8;
	localparam int          CMBF_FRAME_CYC    = CMBF_FRAME_NS / CMBF_CLK_NS;

	typedef struct packed {
		logic        we;
		logic [9:0]  addr;
		logic [15:0] bp_word;
		logic [15:0] lo_word;
		logic [15:0] hi_word;
	} cmbf_wr_t;
endpackage : cmbf_pkg

/* verilog/cmbf_frame_div.sv */
module cmbf_frame_div
	import cmbf_pkg::*;
#(
	parameter int FRAME_CYC = CMBF_FRAME_CYC
) (
	input  wire logic pclk,        // System clock.
	input  wire logic presetn,     // Asynchronous reset, active low.
	output logic      frame_tick   // One-cycle pulse per frame.
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;

	// Counts cycles and wraps once per frame.
	always_comb begin
		if (cnt_q == 32'(FRAME_CYC - 1)) begin
			cnt_d = 32'h0;
		end else begin
			cnt_d = cnt_q + 32'h1;
		end
	end

	// Registers the counter.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign frame_tick = (cnt_q == 32'(FRAME_CYC - 1));
endmodule : cmbf_frame_div

/* verification/cmbf_fill_assertions.sv */
module cmbf_fill_chk
	import cmbf_pkg::*;
#(
	parameter int DEPTH     = 1024,
	parameter int FRAME_CYC = CMBF_FRAME_CYC
) (
	input wire logic        pclk,    // Clock.
	input wire logic        presetn, // Reset, active low.
	input wire logic        psel,    // Select.
	input wire logic        penable, // Enable.
	input wire logic        pwrite,  // Direction.
	input wire logic        pready,  // Ready.
	input wire logic        pslverr, // Error.
	input wire logic        busy,    // Fill running.
	input wire logic [11:0] paddr,   // Byte address.
	input wire logic [31:0] pwdata,  // Write data.
	input wire logic [31:0] prdata,  // Read data.
	input wire cmbf_wr_t    mem_wr   // Memory write port.
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Control register accesses taken in this cycle.
	wire ctl_wr = psel && penable && pwrite && paddr == CMBF_OFS_CONTROL;
	wire ctl_rd = psel && penable && !pwrite && paddr == CMBF_OFS_CONTROL;
	sequence s_arm(bit en, bit run); ctl_wr && pwdata[2] == en && busy == run; endsequence
	property p_no_start; s_arm(0, 0) |=> !busy [*3]; endproperty
	property p_bp_pat;
		s_arm(1, 0) ##2 mem_wr.we |-> mem_wr.bp_word[15:13] == $past(pwdata[8:6], 2);
	endproperty
	property p_lo_pat;
		s_arm(1, 0) ##2 mem_wr.we |-> mem_wr.lo_word[15:13] == $past(pwdata[5:3], 2);
	endproperty
	property p_bp_zero; mem_wr.we |-> mem_wr.bp_word[12:0] == 13'h0000; endproperty
	property p_lo_zero; mem_wr.we |-> mem_wr.lo_word[12:0] == 13'h0000 && mem_wr.hi_word == 16'h0000; endproperty
	property p_fields; ctl_rd |-> prdata[31:9] == 23'h000000 && prdata[1:0] == 2'h0; endproperty
	property p_abort; s_arm(0, 1) |-> ##[1:2] !busy; endproperty
	property p_we_busy; mem_wr.we |-> busy; endproperty
	a_no_start: assert property (p_no_start) else $error("fill started without enable");
	a_bp_pat: assert property (p_bp_pat) else $error("backplane pattern wrong");
	a_bp_zero: assert property (p_bp_zero) else $error("backplane low bits set");
	a_lo_pat: assert property (p_lo_pat) else $error("local pattern wrong");
	a_lo_zero: assert property (p_lo_zero) else $error("local bits not cleared");
	a_fields: assert property (p_fields) else $error("reserved control bits read high");
	a_abort: assert property (p_abort) else $error("abort did not stop fill");
	a_we_busy: assert property (p_we_busy) else $error("write outside fill");
endmodule : cmbf_fill_chk

/* verification/tb_cmbf_fill.sv */
module tb_cmbf_fill import cmbf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FC = 64;
	localparam int DP = 16;
	logic [9:0]  exp_addr = 0;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, busy, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [2:0]  bp, lp;
	cmbf_wr_t    mem_wr;
	int          errors = 0, compares = 0, n;
	cmbf_fill #(.DEPTH(DP), .FRAME_CYC(FC)) cmbf_fill_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_wr(mem_wr), .busy(busy));
	initial forever #4 pclk = ~pclk;
	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1) begin
			errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chk
	// One APB transfer, held until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask : apb
	function automatic logic [15:0] pat(input logic [2:0] p);
		return {p, 13'h0000};
	endfunction : pat
	task automatic give_verdict;
		if (errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	// Every fill word carries the armed patterns with all other bits clear.
	always @(negedge pclk)
		if (mem_wr.we === 1'b1) begin
			chk(mem_wr.bp_word === pat(bp) && mem_wr.lo_word === pat(lp) && mem_wr.hi_word === 0, "word");
			chk(mem_wr.addr === exp_addr, "address");
			exp_addr = (exp_addr == 10'(DP - 1)) ? exp_addr : exp_addr + 10'h001;
		end else
			exp_addr = 10'h000;
	initial begin
		#100us errors++;
		give_verdict();
	end
	initial begin
		n = $urandom(32'hfea4);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, CMBF_OFS_CONTROL, 0);
		chk(rd === 0, "reset value");
		apb(0, 12'h00C, 0);
		chk(err === 1'b1 && rd === 0, "unmapped");
		apb(1, CMBF_OFS_CONTROL, 32'h1FC);
		repeat (20) @(posedge pclk);
		chk(busy === 1'b0, "started without master");
		apb(1, CMBF_OFS_CONTROL, 0);
		apb(1, CMBF_OFS_MAIN, 1);
		apb(0, CMBF_OFS_MAIN, 0);
		chk(rd === 1 && err === 1'b0, "master allow");
		for (int i = 0; i < 4; i++) begin
			bp = i ? 3'($urandom) : 3'h7;
			lp = i ? 3'($urandom) : 3'h0;
			apb(1, CMBF_OFS_CONTROL, ($urandom & 32'hFFFFFE03) | 32'({bp, lp, 3'b100}));
			apb(0, CMBF_OFS_CONTROL, 0);
			chk(rd === {bp, lp, 3'b100} && busy === 1'b1 && err === 1'b0, "armed");
			apb(0, CMBF_OFS_STATUS, 0);
			chk(rd[0] === 1'b1 && rd[31:2] === 30'h0 && err === 1'b0, "status busy");
			if (i == 3)
				apb(1, CMBF_OFS_CONTROL, {bp, lp, 3'b000});
			for (n = 0; busy === 1'b1 && n < 3 * FC; n++)
				@(posedge pclk);
			chk(i == 3 ? n <= 2 : n > FC - 8 && n <= 2 * FC, "fill length");
			apb(0, CMBF_OFS_CONTROL, 0);
			chk(rd === {bp, lp, 3'b000}, "enable cleared");
		end
		give_verdict();
	end
endmodule : tb_cmbf_fill
bind cmbf_fill cmbf_fill_chk #(.DEPTH(DEPTH), .FRAME_CYC(FRAME_CYC)) cmbf_fill_chk_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .pslverr(pslverr), .busy(busy), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .mem_wr(mem_wr));
